// >>> hdl/wim_regs.svh
/*
 Timing counts and field codes for the wake input monitor.
 Assumes a 125 MHz core clock; included by its bare name.
*/
// Overview of operation
// - Both rising and falling threshold crossings of a wake pin signal an event.
// - Event raises interrupt in normal or stop mode, wake in sleep or fail-safe.
// - Static sensing keeps each wake input always active, no timer gating.
// - Cyclic sensing evaluates a pin only inside the assigned timer on-window.
// - Each crossing restarts the filter; event accepted if stable for filter time.
// - Wake capability is enabled separately per pin by the wake enable control.
// - One sticky status bit per pin records which pin caused a wake.
// - Normal and stop modes expose each pin level, enabled or not.
// - Under cyclic sensing the level status holds the last window sample.
// - Alternate outputs as wake inputs use fixed 16 us filter, own status.
// - Bias field: 00 none, 01 pull-down, 10 pull-up, 11 automatic.
// - Automatic bias pulls up on high level and pulls down on low level.
// - Detect field: 00 static 16us, 01 static 64us, 10/11 cyclic timer one/two.
// - Cyclic window period and on-time come from the selected timer control.
`ifndef WIM_REGS_SVH
`define WIM_REGS_SVH

`define WIM_CLK_MHZ        125
`define WIM_FILT_SHORT_US  16
`define WIM_FILT_LONG_US   64
`define WIM_TICK_US        1
`define WIM_TICK_CYC       (`WIM_TICK_US * `WIM_CLK_MHZ)

`define WIM_BIAS_NONE      2'h0
`define WIM_BIAS_DOWN      2'h1
`define WIM_BIAS_UP        2'h2
`define WIM_BIAS_AUTO      2'h3

`define WIM_DET_STATIC16   2'h0
`define WIM_DET_STATIC64   2'h1
`define WIM_DET_CYCLIC_T1  2'h2
`define WIM_DET_CYCLIC_T2  2'h3

`define WIM_NUM_WAKE       3
`define WIM_NUM_ALT        2
`define WIM_CNT_W          14
`define WIM_TMR_W          16

`endif

// >>> hdl/wim_pkg.sv
/*
 Types shared by the wake input monitor.
 Assumes nothing of its surroundings.
*/
package wim_pkg;
   typedef enum logic [1:0] {
      WIM_MODE_NORMAL,
      WIM_MODE_STOP,
      WIM_MODE_SLEEP,
      WIM_MODE_FAILSAFE
   } wim_mode_t;
endpackage

// >>> hdl/wim_filt_if.sv
/*
 Carrier between the top and one edge filter.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface wim_filt_if;
   logic pinRaw;
   logic active;
   logic useLong;
   logic edgeEvt;
   logic stableLvl;
   logic syncLvl;
   modport filt (input pinRaw, input active, input useLong,
                 output edgeEvt, output stableLvl, output syncLvl);
   modport ctrl (output pinRaw, output active, output useLong,
                 input edgeEvt, input stableLvl, input syncLvl);
endinterface

// >>> hdl/wim_edge_filter.sv
/*
 Synchroniser and crossing filter for one wake input.
 Assumes an asynchronous pin level and a shared core clock.
*/
`timescale 1ns/1ps
`include "wim_regs.svh"
module wim_edge_filter #(
   parameter int ShortCyc = 2000,
   parameter int LongCyc  = 8000
) (
   input wire logic clk,
   input wire logic rst,
   wim_filt_if.filt f
);
   logic                 sync1_q;
   logic                 sync2_q;
   logic                 stable_q;
   logic                 evt_q;
   logic [`WIM_CNT_W-1:0] cnt_q;
   logic [`WIM_CNT_W-1:0] lim;

   // ----------------------------------------
   // synchroniser
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end
      else
      begin
         sync1_q <= f.pinRaw;
         sync2_q <= sync1_q;
      end
   end

   assign lim = f.useLong ? `WIM_CNT_W'(LongCyc - 1) : `WIM_CNT_W'(ShortCyc - 1);

   // ----------------------------------------
   // crossing filter
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_q <= '0;
      else if (!f.active || sync2_q == stable_q)
         cnt_q <= '0;
      else if (cnt_q == lim)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + `WIM_CNT_W'(1);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stable_q <= 1'b0;
         evt_q    <= 1'b0;
      end
      else
      begin
         evt_q <= 1'b0;
         if (f.active && sync2_q != stable_q && cnt_q == lim)
         begin
            stable_q <= sync2_q;
            evt_q    <= 1'b1;
         end
      end
   end

   assign f.edgeEvt   = evt_q;
   assign f.stableLvl = stable_q;
   assign f.syncLvl   = sync2_q;
endmodule

// >>> hdl/wim_wake_monitor.sv
/*
 Wake input monitor: three wake pins, two alternate pins, cyclic timers,
 bias control, wake and level status.
 Assumes asynchronous pin levels and control ports from the core clock domain.
*/
`timescale 1ns/1ps
`include "wim_regs.svh"
module wim_wake_monitor #(
   parameter int FiltShortCyc = `WIM_FILT_SHORT_US * `WIM_CLK_MHZ,
   parameter int FiltLongCyc  = `WIM_FILT_LONG_US * `WIM_CLK_MHZ
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [2:0]              wakeInputPin,
   input  wire logic [1:0]              altFunctionOutputs,
   input  wire logic [1:0]              altWakeSelect,
   input  wire wim_pkg::wim_mode_t      sbcMode,
   input  wire logic [2:0]              wakeEnableControl,
   input  wire logic [5:0]              wakeBiasControl,
   input  wire logic [5:0]              wakeFilterControl,
   input  wire logic [`WIM_TMR_W-1:0]   timerOnePeriod,
   input  wire logic [`WIM_TMR_W-1:0]   timerOneOnTime,
   input  wire logic [`WIM_TMR_W-1:0]   timerTwoPeriod,
   input  wire logic [`WIM_TMR_W-1:0]   timerTwoOnTime,
   input  wire logic [2:0]              wakeSourceClear,
   input  wire logic [1:0]              altWakeClear,
   output logic                         intReq,
   output logic                         wakeReq,
   output logic [2:0]                   wakeSourceStatus,
   output logic [1:0]                   altPinWakeStatus,
   output logic [2:0]                   wakePinLevelStatus,
   output logic [2:0]                   pullUpEn,
   output logic [2:0]                   pullDownEn
);
   localparam int NW = `WIM_NUM_WAKE;
   localparam int NA = `WIM_NUM_ALT;

   logic [6:0]            tick_q;
   logic                  tickEn;
   logic [`WIM_TMR_W-1:0] tmrCnt_q [2];
   logic [1:0]            window;
   logic [NW+NA-1:0]      evt;
   logic [NW+NA-1:0]      stable;
   logic [NW+NA-1:0]      syncd;
   logic [NW-1:0]         wakeEvt;
   logic                  anyEvt;
   logic                  awake;
   logic [2:0]            src_q;
   logic [1:0]            alt_q;
   logic [2:0]            lvl_q;
   logic                  int_q;
   logic                  wak_q;
   logic [2:0]            pu_q;
   logic [2:0]            pd_q;

   wim_filt_if fi [NW+NA] ();

   function automatic logic isCyclic(input logic [1:0] det);
      return det == `WIM_DET_CYCLIC_T1 || det == `WIM_DET_CYCLIC_T2;
   endfunction

   function automatic logic inWindow(input logic [`WIM_TMR_W-1:0] cnt,
                                     input logic [`WIM_TMR_W-1:0] onTime);
      return cnt < onTime;
   endfunction

   // ----------------------------------------
   // cyclic sense timers
   // ----------------------------------------
   assign tickEn = (tick_q == 7'(`WIM_TICK_CYC - 1));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         tick_q <= 7'h00;
      else if (tickEn)
         tick_q <= 7'h00;
      else
         tick_q <= tick_q + 7'h01;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tmrCnt_q[0] <= '0;
         tmrCnt_q[1] <= '0;
      end
      else if (tickEn)
      begin
         // period and on-time from the selected timer control
         tmrCnt_q[0] <= (tmrCnt_q[0] + 16'h0001 >= timerOnePeriod) ? '0
                        : tmrCnt_q[0] + 16'h0001;
         tmrCnt_q[1] <= (tmrCnt_q[1] + 16'h0001 >= timerTwoPeriod) ? '0
                        : tmrCnt_q[1] + 16'h0001;
      end
   end

   assign window[0] = inWindow(tmrCnt_q[0], timerOneOnTime);
   assign window[1] = inWindow(tmrCnt_q[1], timerTwoOnTime);

   // ----------------------------------------
   // filters
   // ----------------------------------------
   for (genvar i = 0; i < NW + NA; i++)
   begin : g_filt
      if (i < NW)
      begin : g_wk
         logic [1:0] det;
         assign det = wakeFilterControl[2*i +: 2];
         assign fi[i].pinRaw  = wakeInputPin[i];
         assign fi[i].useLong = (det == `WIM_DET_STATIC64);
         assign fi[i].active  = !isCyclic(det) ? 1'b1
                                : window[det[0]];
      end
      else
      begin : g_alt
         assign fi[i].pinRaw  = altFunctionOutputs[i-NW];
         assign fi[i].useLong = 1'b0;
         assign fi[i].active  = altWakeSelect[i-NW];
      end
      assign evt[i]    = fi[i].edgeEvt;
      assign stable[i] = fi[i].stableLvl;
      assign syncd[i]  = fi[i].syncLvl;

      wim_edge_filter #(
         .ShortCyc (FiltShortCyc),
         .LongCyc  (FiltLongCyc)
      ) u_filt (
         .clk (clk),
         .rst (rst),
         .f   (fi[i])
      );
   end

   // ----------------------------------------
   // event signalling
   // ----------------------------------------
   assign wakeEvt = evt[NW-1:0] & wakeEnableControl;
   assign anyEvt  = (|wakeEvt) | (|(evt[NW+NA-1:NW] & altWakeSelect));
   assign awake   = (sbcMode == wim_pkg::WIM_MODE_NORMAL) ||
                    (sbcMode == wim_pkg::WIM_MODE_STOP);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         int_q <= 1'b0;
         wak_q <= 1'b0;
      end
      else
      begin
         int_q <= anyEvt && awake;
         wak_q <= anyEvt && !awake;
      end
   end

   // ----------------------------------------
   // status flags, set wins over clear
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         src_q <= 3'h0;
         alt_q <= 2'h0;
      end
      else
      begin
         src_q <= (src_q & ~wakeSourceClear) | wakeEvt;
         alt_q <= (alt_q & ~altWakeClear)
                  | (evt[NW+NA-1:NW] & altWakeSelect);
      end
   end

   // ----------------------------------------
   // level status and bias
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         lvl_q <= 3'h0;
      else if (awake)
         for (int i = 0; i < NW; i++)
            lvl_q[i] <= isCyclic(wakeFilterControl[2*i +: 2]) ? stable[i]
                        : syncd[i];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pu_q <= 3'h0;
         pd_q <= 3'h0;
      end
      else
         for (int i = 0; i < NW; i++)
         begin
            unique case (wakeBiasControl[2*i +: 2])
               `WIM_BIAS_NONE:
               begin
                  pu_q[i] <= 1'b0;
                  pd_q[i] <= 1'b0;
               end
               `WIM_BIAS_DOWN:
               begin
                  pu_q[i] <= 1'b0;
                  pd_q[i] <= 1'b1;
               end
               `WIM_BIAS_UP:
               begin
                  pu_q[i] <= 1'b1;
                  pd_q[i] <= 1'b0;
               end
               `WIM_BIAS_AUTO:
               begin
                  pu_q[i] <= syncd[i];
                  pd_q[i] <= !syncd[i];
               end
            endcase
         end
   end

   assign intReq             = int_q;
   assign wakeReq            = wak_q;
   assign wakeSourceStatus   = src_q;
   assign altPinWakeStatus   = alt_q;
   assign wakePinLevelStatus = lvl_q;
   assign pullUpEn           = pu_q;
   assign pullDownEn         = pd_q;
endmodule

// >>> sim/wim_switch_model.sv
/*
 External switches on the three wake pins.
 Assumes pull enables come from the monitor.
*/
`timescale 1ns/1ps
module wim_switch_model (
   input  wire logic [2:0] closedSw,
   input  wire logic [2:0] swLevel,
   input  wire logic [2:0] pullUpEn,
   input  wire logic [2:0] pullDownEn,
   input  wire logic       clk,
   output logic [2:0]      pinLvl
);
   logic [2:0] wander_q;
   // an open pin with no bias wanders every cycle
   always_ff @(posedge clk)
      wander_q <= ~pinLvl;
   always_comb
      for (int i = 0; i < 3; i++)
         pinLvl[i] = closedSw[i] ? swLevel[i] : pullUpEn[i] ? 1'b1 :
                     pullDownEn[i] ? 1'b0 : wander_q[i];
endmodule

// >>> sim/wim_props.sv
/*
 Port checker for the wake input monitor.
 Assumes binding to wim_wake_monitor.
*/
`timescale 1ns/1ps
module wim_props (
   input wire logic               clk,
   input wire logic               rst,
   input wire logic [2:0]         wakeInputPin,
   input wire wim_pkg::wim_mode_t sbcMode,
   input wire logic [2:0]         wakeEnableControl,
   input wire logic [5:0]         wakeBiasControl,
   input wire logic [5:0]         wakeFilterControl,
   input wire logic [2:0]         wakeSourceClear,
   input wire logic               intReq,
   input wire logic               wakeReq,
   input wire logic [2:0]         wakeSourceStatus,
   input wire logic [2:0]         wakePinLevelStatus,
   input wire logic [2:0]         pullUpEn,
   input wire logic [2:0]         pullDownEn
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // pin 0 quiet, normal mode, static sensing
   sequence s_pin0_quiet;
      ($stable(wakeInputPin[0]) && sbcMode == wim_pkg::WIM_MODE_NORMAL
         && wakeFilterControl[1:0] == 2'h0) [*4];
   endsequence
   sequence s_status_rise;
      |(wakeSourceStatus & ~$past(wakeSourceStatus));
   endsequence
   a_int_mode_gate: assert property (intReq |-> !$past(sbcMode[1]))
      else $error("intReq outside normal or stop");
   a_wake_mode_gate: assert property (wakeReq |-> $past(sbcMode[1]))
      else $error("wakeReq outside sleep or fail-safe");
   a_status_sticky: assert property (
      !(|($past(wakeSourceStatus) & ~wakeSourceStatus & ~$past(wakeSourceClear))))
      else $error("status bit lost without clear");
   a_status_cause: assert property (s_status_rise |-> intReq || wakeReq)
      else $error("status set without event pulse");
   a_enable_gate: assert property (
      !(|(wakeSourceStatus & ~$past(wakeSourceStatus) & ~$past(wakeEnableControl))))
      else $error("disabled pin set its status");
   a_bias_fixed: assert property (
      !$past(rst) && !$past(wakeBiasControl[1])
      |-> pullDownEn[0] == $past(wakeBiasControl[0]) && !pullUpEn[0])
      else $error("pin 0 bias decode wrong");
   a_bias_exclusive: assert property (!(|(pullUpEn & pullDownEn)))
      else $error("pull-up and pull-down both on");
   a_level_hold: assert property (
      !$past(rst) && $past(sbcMode[1]) |-> $stable(wakePinLevelStatus))
      else $error("level status moved in low power mode");
   a_level_live: assert property (
      s_pin0_quiet |-> wakePinLevelStatus[0] == wakeInputPin[0])
      else $error("pin 0 level status not live");
endmodule
bind wim_wake_monitor wim_props u_props (.clk, .rst, .wakeInputPin, .sbcMode,
   .wakeEnableControl, .wakeBiasControl, .wakeFilterControl, .wakeSourceClear, .intReq,
   .wakeReq, .wakeSourceStatus, .wakePinLevelStatus, .pullUpEn, .pullDownEn);

// >>> sim/wim_tb.sv
/*
 Self-checking bench for the wake input monitor.
 Assumes short filter counts of 8 and 32 cycles.
*/
`timescale 1ns/1ps
module testbench;
   logic               clk, rst, intReq, wakeReq, gi, gw;
   logic [2:0]         closedSw, swLevel, pinLvl, wakeEnableControl, wakeSourceClear;
   logic [2:0]         wss, lvl, pu, pd;
   logic [1:0]         altFunctionOutputs, altWakeSelect, altWakeClear, alt;
   logic [5:0]         wakeBiasControl, wakeFilterControl;
   logic [15:0]        timerOnePeriod, timerOneOnTime, timerTwoPeriod, timerTwoOnTime;
   logic [16:0]        lf;
   wim_pkg::wim_mode_t sbcMode;
   int                 err_total = 0, cmp_count = 0, cyc = 0;

   wim_wake_monitor #(.FiltShortCyc(8), .FiltLongCyc(32)) uut (.clk, .rst,
      .wakeInputPin(pinLvl), .altFunctionOutputs, .altWakeSelect, .sbcMode,
      .wakeEnableControl, .wakeBiasControl, .wakeFilterControl, .timerOnePeriod,
      .timerOneOnTime, .timerTwoPeriod, .timerTwoOnTime, .wakeSourceClear, .altWakeClear,
      .intReq, .wakeReq, .wakeSourceStatus(wss), .altPinWakeStatus(alt),
      .wakePinLevelStatus(lvl), .pullUpEn(pu), .pullDownEn(pd));
   wim_switch_model sw (.closedSw, .swLevel, .pullUpEn(pu), .pullDownEn(pd), .clk, .pinLvl);

   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // gather int and wake pulses over n cycles
   task automatic watch(input int n);
      gi = 0;
      gw = 0;
      repeat (n)
      begin
         step(1);
         gi |= intReq;
         gw |= wakeReq;
      end
   endtask
   task automatic ev(input int p, input logic v, input int n, input logic [1:0] e);
      swLevel[p] = v;
      watch(n);
      chk("event", {gi, gw}, e);
   endtask
   task automatic test_done;
      $display("Comparisons %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_total++;
         test_done;
      end
   end

   initial
   begin
      {rst, closedSw, lf} = {1'b1, 3'h7, 17'h17999};
      {swLevel, wakeSourceClear, wakeEnableControl} = {3'h0, 3'h0, 3'h5};
      {altFunctionOutputs, altWakeSelect, altWakeClear} = 6'h00;
      {wakeBiasControl, wakeFilterControl} = 12'h000;
      {timerOnePeriod, timerOneOnTime} = {16'h0004, 16'h0000};
      {timerTwoPeriod, timerTwoOnTime} = {16'h0004, 16'h0004};
      sbcMode = wim_pkg::WIM_MODE_NORMAL;
      step(2);
      rst = 0;
      step(1);
      chk("reset", {wss, alt, pu, pd, intReq}, 12'h000);
      ev(0, 1'b1, 20, 2'h2);
      chk("status", {wss, lvl}, 6'h09);
      wakeSourceClear = 3'h7;
      step(1);
      wakeSourceClear = 3'h0;
      chk("clear", wss, 3'h0);
      sbcMode = wim_pkg::WIM_MODE_STOP;
      ev(0, 1'b0, 20, 2'h2);
      repeat (8)
      begin
         lf = lfsr(lf);
         swLevel[0] = 1'b1;
         step(1 + lf[2:0] % 6);
         ev(0, 1'b0, 20, 2'h0);
      end
      // two sync flops, eight filter cycles, one output register
      swLevel[0] = 1'b1;
      step(10);
      chk("early", intReq, 1'b0);
      step(1);
      chk("latency", intReq, 1'b1);
      ev(0, 1'b0, 20, 2'h2);
      wakeFilterControl = 6'h01;
      swLevel[0] = 1'b1;
      step(20);
      ev(0, 1'b0, 40, 2'h0);
      ev(0, 1'b1, 45, 2'h2);
      ev(1, 1'b1, 20, 2'h0);
      chk("status", {wss, lvl}, 6'h0B);
      sbcMode = wim_pkg::WIM_MODE_FAILSAFE;
      ev(2, 1'b1, 20, 2'h1);
      chk("status", {wss, lvl}, 6'h2B);
      sbcMode = wim_pkg::WIM_MODE_SLEEP;
      ev(2, 1'b0, 20, 2'h1);
      sbcMode = wim_pkg::WIM_MODE_NORMAL;
      wakeFilterControl = 6'h02;
      ev(0, 1'b0, 40, 2'h0);
      chk("cyclic", lvl, 3'h3);
      wakeFilterControl = 6'h03;
      watch(20);
      chk("window", {gi, lvl}, 4'hA);
      // one microsecond on in every four: the event waits for a window
      {timerOneOnTime, wakeFilterControl} = {16'h0001, 6'h02};
      swLevel[0] = 1'b1;
      watch(520);
      chk("period", {gi, lvl[0]}, 2'h3);
      altWakeSelect = 2'h1;
      altFunctionOutputs = 2'h3;
      watch(20);
      chk("alt", {gi, alt}, 3'h5);
      altWakeClear = 2'h3;
      step(1);
      altWakeClear = 2'h0;
      chk("altclear", alt, 2'h0);
      for (int c = 0; c < 3; c++)
      begin
         wakeBiasControl = {3{c[1:0]}};
         step(3);
         chk("bias", {pu, pd}, {{3{c == 2}}, {3{c == 1}}});
      end
      wakeBiasControl = 6'h3F;
      repeat (4)
      begin
         lf = lfsr(lf);
         swLevel = lf[2:0];
         step(5);
         chk("auto", {pu, pd}, {lf[2:0], ~lf[2:0]});
      end
      closedSw = 3'h0;
      step(5);
      chk("float", {pu, pd}, {lf[2:0], ~lf[2:0]});
      test_done;
   end
endmodule
